// >>> core/icu_top.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - each qualifying event copies the whole 16-bit timer count.
// - events: falling, rising, every 4th rising, every 16th rising.
// - a capture sets a sticky flag; only software clears it.
// - a new capture overwrites the old value without overrun guard.
// - two identical independent units share one timer count.
// - pin level is observed even while the pin drives out.
// - a mode change may give a spurious capture; not suppressed.
// - prescaler held clear when unit off or not capturing.
// - any reset clears the prescaler counter.
// - switching prescale directly keeps the count; false capture possible.
// - unit 2 pin selectable between two device pins.
// - capture works in sleep only with an externally clocked timer.
module icu_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] timerCount,
	input wire logic unit1PinIn,
	input wire logic unit2PinIn,
	input wire logic unit2AltPinIn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq
);
	localparam int UNITS = 2;

	typedef struct packed {
		logic [UNITS-1:0] pinMeta;
		logic [UNITS-1:0] pinSync;
		logic [icu_pkg::CTRL_W-1:0] ctrl1;
		logic [icu_pkg::CTRL_W-1:0] ctrl2;
		logic [UNITS-1:0] flags;
		logic [UNITS-1:0] irqEn;
		logic altSel;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic irqOut;
	} icu_top_s;

	icu_top_s state_reg;
	icu_top_s state_next;
	logic [UNITS-1:0] rawPin;
	logic [UNITS-1:0] capEvent;
	logic [15:0] capValue [UNITS];
	logic [3:0] unitMode [UNITS];
	logic doWrite;
	logic doRead;
	logic [31:0] wMasked;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// a mapped word must be one of the listed offsets
	function automatic logic addrOk(input logic [7:0] a);
		case (a)
		icu_pkg::OFF_UNIT1_CTRL, icu_pkg::OFF_UNIT2_CTRL,
		icu_pkg::OFF_UNIT1_VAL, icu_pkg::OFF_UNIT2_VAL,
		icu_pkg::OFF_FLAGS, icu_pkg::OFF_IRQ_EN,
		icu_pkg::OFF_ALT_PIN, icu_pkg::OFF_TIMER: addrOk = 1'b1;
		default: addrOk = 1'b0;
		endcase
	endfunction

	// apply byte strobes to an old word
	function automatic logic [31:0] strobe(input logic [31:0] oldv,
		input logic [31:0] newv, input logic [3:0] st);
		logic [31:0] r;
		r = oldv;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = newv[i*8 +: 8];
			end
		end
		strobe = r;
	endfunction

	// ----------------------------------------
	// pin selection and capture units
	// ----------------------------------------
	// direction is not looked at: a driven pin still reads back
	assign rawPin[0] = unit1PinIn;
	assign rawPin[1] = state_reg.altSel ? unit2AltPinIn : unit2PinIn;
	assign unitMode[0] = state_reg.ctrl1[icu_pkg::MODE_LSB +: icu_pkg::MODE_W];
	assign unitMode[1] = state_reg.ctrl2[icu_pkg::MODE_LSB +: icu_pkg::MODE_W];

	// two identical units on one timer
	generate
		for (genvar g = 0; g < UNITS; g++) begin : gUnit
			icu_cap_if capBus ();
			assign capBus.mode = unitMode[g];
			// no sleep state here: capture runs whenever ref_clk runs
			assign capBus.timerCount = timerCount;
			assign capBus.pinSync = state_reg.pinSync[g];
			assign capValue[g] = capBus.capValue;
			assign capEvent[g] = capBus.capEvent;
			icu_capture_unit uUnit (
				.ref_clk(ref_clk),
				.rst(rst),
				.cap(capBus)
			);
		end
	endgenerate

	// ----------------------------------------
	// bus slave, flags and interrupt
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		// two-flop synchroniser on pins
		state_next.pinMeta = rawPin;
		state_next.pinSync = state_reg.pinMeta;
		// write channels accepted separately, in either order
		if (s_axi_awvalid && !state_reg.awHeld) begin
			state_next.awHeld = 1'b1;
			state_next.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !state_reg.wHeld) begin
			state_next.wHeld = 1'b1;
			state_next.wData = s_axi_wdata;
			state_next.wStrb = s_axi_wstrb;
		end
		doWrite = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;
		wMasked = strobe(32'h0000_0000, state_reg.wData, state_reg.wStrb);
		if (doWrite) begin
			state_next.awHeld = 1'b0;
			state_next.wHeld = 1'b0;
			state_next.bValid = 1'b1;
			state_next.bResp = addrOk(state_reg.awAddr) ?
				icu_pkg::RESP_OKAY : icu_pkg::RESP_SLVERR;
			case (state_reg.awAddr)
			icu_pkg::OFF_UNIT1_CTRL: if (state_reg.wStrb[0]) begin
				state_next.ctrl1 = state_reg.wData[icu_pkg::CTRL_W-1:0];
			end
			icu_pkg::OFF_UNIT2_CTRL: if (state_reg.wStrb[0]) begin
				state_next.ctrl2 = state_reg.wData[icu_pkg::CTRL_W-1:0];
			end
			icu_pkg::OFF_FLAGS: begin
				// write one to clear
				state_next.flags = state_reg.flags & ~wMasked[UNITS-1:0];
			end
			icu_pkg::OFF_IRQ_EN: if (state_reg.wStrb[0]) begin
				state_next.irqEn = state_reg.wData[UNITS-1:0];
			end
			icu_pkg::OFF_ALT_PIN: if (state_reg.wStrb[0]) begin
				state_next.altSel = state_reg.wData[0];
			end
			default: ;
			endcase
		end
		if (state_reg.bValid && s_axi_bready) begin
			state_next.bValid = 1'b0;
		end
		// set after clear so a same-cycle capture wins
		state_next.flags = state_next.flags | capEvent;
		// reads: one outstanding, data from registers
		doRead = s_axi_arvalid && !state_reg.rValid;
		if (doRead) begin
			state_next.rValid = 1'b1;
			state_next.rResp = addrOk(s_axi_araddr) ?
				icu_pkg::RESP_OKAY : icu_pkg::RESP_SLVERR;
			state_next.rData = 32'h0000_0000;
			case (s_axi_araddr)
			icu_pkg::OFF_UNIT1_CTRL: state_next.rData[icu_pkg::CTRL_W-1:0] =
				state_reg.ctrl1;
			icu_pkg::OFF_UNIT2_CTRL: state_next.rData[icu_pkg::CTRL_W-1:0] =
				state_reg.ctrl2;
			icu_pkg::OFF_UNIT1_VAL: state_next.rData[15:0] = capValue[0];
			icu_pkg::OFF_UNIT2_VAL: state_next.rData[15:0] = capValue[1];
			icu_pkg::OFF_FLAGS: state_next.rData[UNITS-1:0] = state_reg.flags;
			icu_pkg::OFF_IRQ_EN: state_next.rData[UNITS-1:0] = state_reg.irqEn;
			icu_pkg::OFF_ALT_PIN: state_next.rData[0] = state_reg.altSel;
			icu_pkg::OFF_TIMER: state_next.rData[15:0] = timerCount;
			default: ;
			endcase
		end
		if (state_reg.rValid && s_axi_rready) begin
			state_next.rValid = 1'b0;
		end
		// level interrupt from unmasked sticky flags
		state_next.irqOut = |(state_next.flags & state_reg.irqEn);
	end

	// single registered state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// handshake and data outputs
	assign s_axi_awready = !state_reg.awHeld;
	assign s_axi_wready = !state_reg.wHeld;
	assign s_axi_bvalid = state_reg.bValid;
	assign s_axi_bresp = state_reg.bResp;
	assign s_axi_arready = !state_reg.rValid;
	assign s_axi_rvalid = state_reg.rValid;
	assign s_axi_rdata = state_reg.rData;
	assign s_axi_rresp = state_reg.rResp;
	assign irq = state_reg.irqOut;
endmodule // icu_top

// >>> core/icu_pkg.sv
package icu_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_UNIT1_CTRL = 8'h00;
	localparam logic [7:0] OFF_UNIT2_CTRL = 8'h04;
	localparam logic [7:0] OFF_UNIT1_VAL = 8'h08;
	localparam logic [7:0] OFF_UNIT2_VAL = 8'h0C;
	localparam logic [7:0] OFF_FLAGS = 8'h10;
	localparam logic [7:0] OFF_IRQ_EN = 8'h14;
	localparam logic [7:0] OFF_ALT_PIN = 8'h18;
	localparam logic [7:0] OFF_TIMER = 8'h1C;
	// control field layout
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 4;
	localparam int DUTY_LSB = 4;
	localparam int DUTY_W = 2;
	localparam int CTRL_W = 6;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	// capture mode encodings
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_FALL = 4'h4;
	localparam logic [3:0] MODE_RISE = 4'h5;
	localparam logic [3:0] MODE_RISE4 = 4'h6;
	localparam logic [3:0] MODE_RISE16 = 4'h7;
	// prescaler terminal counts
	localparam logic [3:0] PRE_LAST4 = 4'h3;
	localparam logic [3:0] PRE_LAST16 = 4'hF;
	localparam logic [3:0] PRE_ZERO = 4'h0;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> core/icu_cap_if.sv
`timescale 1ns/1ps
// one capture unit's control and results
interface icu_cap_if;
	logic [3:0] mode;
	logic [15:0] timerCount;
	logic pinSync;
	logic [15:0] capValue;
	logic capEvent;
	modport unit (input mode, input timerCount, input pinSync,
		output capValue, output capEvent);
	modport top (output mode, output timerCount, output pinSync,
		input capValue, input capEvent);
endinterface

// >>> core/icu_capture_unit.sv
`timescale 1ns/1ps
module icu_capture_unit (
	input wire logic ref_clk,
	input wire logic rst,
	icu_cap_if.unit cap
);
	typedef struct packed {
		logic pinPrev;
		logic [3:0] preCount;
		logic [3:0] lastMode;
		logic [15:0] capValue;
		logic capEvent;
	} icu_unit_s;

	icu_unit_s state_reg;
	icu_unit_s state_next;
	logic rise;
	logic fall;
	logic hit;

	// ----------------------------------------
	// edge detection and prescaler
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.pinPrev = cap.pinSync;
		state_next.lastMode = cap.mode;
		state_next.capEvent = 1'b0;
		rise = cap.pinSync & ~state_reg.pinPrev;
		fall = ~cap.pinSync & state_reg.pinPrev;
		hit = 1'b0;
		// mode change between prescales keeps the count; a switch may
		// therefore produce a spurious capture, which is not masked
		case (cap.mode)
		icu_pkg::MODE_FALL: hit = fall;
		icu_pkg::MODE_RISE: hit = rise;
		icu_pkg::MODE_RISE4: begin
			if (rise) begin
				hit = (state_reg.preCount >= icu_pkg::PRE_LAST4);
				state_next.preCount = hit ? icu_pkg::PRE_ZERO :
					state_reg.preCount + 4'h1;
			end
		end
		icu_pkg::MODE_RISE16: begin
			if (rise) begin
				hit = (state_reg.preCount == icu_pkg::PRE_LAST16);
				state_next.preCount = state_reg.preCount + 4'h1;
			end
		end
		default: state_next.preCount = icu_pkg::PRE_ZERO;
		endcase
		if (hit) begin
			state_next.capValue = cap.timerCount;
			state_next.capEvent = 1'b1;
		end
	end

	// reset clears prescaler and value
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign cap.capValue = state_reg.capValue;
	assign cap.capEvent = state_reg.capEvent;
endmodule // icu_capture_unit

// >>> verif/icu_props.sv
`timescale 1ns/1ps
module icu_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [15:0] timerCount,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// handshakes that open a write or a read
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// irq low after reset; responses hold until taken; one read in flight; answer delay; refusals; timer read
	chk_irq_reset: assert property ($fell(rst) |-> !irq)
		else $error("irq high after reset");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("ar open with r pending");
	chk_rd_answer: assert property (s_rd |=> s_axi_rvalid)
		else $error("read answer late");
	chk_wr_answer: assert property (s_wr |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	chk_bad_addr: assert property (s_rd and s_axi_araddr > 8'h1C |=>
		s_axi_rresp == icu_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	chk_timer_read: assert property (s_rd ##0 s_axi_araddr ==
		icu_pkg::OFF_TIMER |=> s_axi_rdata[15:0] == $past(timerCount))
		else $error("timer read wrong");
endmodule // icu_props
bind icu_top icu_props i_props (.*);

// >>> verif/icu_pin_src.sv
`timescale 1ns/1ps
// outside source on the capture pins, idle low between pulses
module icu_pin_src (
	input wire logic ref_clk,
	output logic unit1PinIn,
	output logic unit2PinIn,
	output logic unit2AltPinIn
);
	initial {unit1PinIn, unit2PinIn, unit2AltPinIn} = 3'b000;
	// n pulses, 8 cycles high then 8 low on the chosen pin
	task automatic pulse(input int u, input logic alt, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			if (u == 0) unit1PinIn <= 1'b1;
			else if (alt) unit2AltPinIn <= 1'b1;
			else unit2PinIn <= 1'b1;
			repeat (8) @(posedge ref_clk);
			{unit1PinIn, unit2PinIn, unit2AltPinIn} <= 3'b000;
			repeat (7) @(posedge ref_clk);
		end
	endtask
endmodule // icu_pin_src

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] timerCount = 16'h0000;
	wire unit1PinIn, unit2PinIn, unit2AltPinIn;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	logic [33:0] expQ [$];
	int num_errors = 0;
	int cmp_count = 0;
	int seed = 32'h0000_d36d;
	logic [3:0] modes [4] = '{icu_pkg::MODE_FALL, icu_pkg::MODE_RISE,
		icu_pkg::MODE_RISE4, icu_pkg::MODE_RISE16};
	int reps [4] = '{1, 1, 4, 16};
	icu_top i_dut (.*);
	icu_pin_src i_src (.*);
	always #12.5 ref_clk = ~ref_clk;
	// -------------------------------
	// helpers
	// -------------------------------
	function automatic logic [33:0] ok(input logic [31:0] d);
		return {icu_pkg::RESP_OKAY, d};
	endfunction
	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// ready sampled at the falling edge, acted on at the next rising one
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, bv, bh;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(negedge ref_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			bv = s_axi_bvalid;
			bh = bv && s_axi_bready;
			@(posedge ref_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			s_axi_bready <= bv && !bh;
		end while (!bh);
	endtask
	// rready raised late on purpose so the response must hold
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic ta, rv, hs;
		expQ.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge ref_clk);
			ta = s_axi_arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			hs = rv && s_axi_rready;
			@(posedge ref_clk);
			if (ta) s_axi_arvalid <= 1'b0;
			s_axi_rready <= rv && !hs;
		end while (!hs);
	endtask
	task automatic clr;
		repeat (4) @(posedge ref_clk);
		wr(icu_pkg::OFF_FLAGS, 32'h0000_0003);
	endtask
	task automatic irqIs(input logic e);
		repeat (3) @(negedge ref_clk);
		chk(irq, e);
		@(posedge ref_clk);
	endtask
	task automatic report_and_stop;
		if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// read results compared in order of issue
	always @(negedge ref_clk)
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
	// hang guard, far beyond the expected run
	initial begin
		repeat (30000) @(posedge ref_clk);
		num_errors++;
		report_and_stop();
	end
	// -------------------------------
	// main sequence
	// -------------------------------
	initial begin
		logic [15:0] b;
		logic [15:0] c;
		logic [7:0] ac;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(icu_pkg::OFF_UNIT2_CTRL, ok(0));
		wr(icu_pkg::OFF_UNIT1_CTRL, 32'h0000_0030);
		rd(icu_pkg::OFF_UNIT1_CTRL, ok(32'h0000_0030));
		rd(8'h20, {icu_pkg::RESP_SLVERR, 32'h0000_0000});
		timerCount <= 16'($random(seed));
		@(posedge ref_clk);
		rd(icu_pkg::OFF_TIMER, ok(timerCount));
		for (int u = 0; u < 2; u++) for (int m = 0; m < 4; m++) begin
			ac = icu_pkg::OFF_UNIT1_CTRL + 8'(4 * u);
			wr(ac, 0);
			wr(icu_pkg::OFF_ALT_PIN, m % 2);
			wr(ac, modes[m]);
			clr();
			i_src.pulse(u, m % 2, reps[m] - 1);
			rd(icu_pkg::OFF_FLAGS, ok(0));
			b = 16'($random(seed));
			c = 16'($random(seed));
			timerCount <= b;
			// timer moves between the rise and the fall of the pulse
			fork
				i_src.pulse(u, m % 2, 1);
				begin
					repeat (7) @(posedge ref_clk);
					timerCount <= c;
				end
			join
			rd(icu_pkg::OFF_FLAGS, ok(u + 1));
			rd(ac + 8'h08, ok(m == 0 ? c : b));
			timerCount <= 16'($random(seed));
			i_src.pulse(u, m % 2, reps[m]);
			rd(ac + 8'h08, ok(timerCount));
			wr(ac, m);
			clr();
			i_src.pulse(u, m % 2, 1);
			rd(icu_pkg::OFF_FLAGS, ok(0));
		end
		// direct prescale switch keeps three counted edges
		wr(icu_pkg::OFF_UNIT1_CTRL, icu_pkg::MODE_RISE16);
		clr();
		i_src.pulse(0, 1'b0, 3);
		wr(icu_pkg::OFF_UNIT1_CTRL, icu_pkg::MODE_RISE4);
		clr();
		i_src.pulse(0, 1'b0, 1);
		rd(icu_pkg::OFF_FLAGS, ok(1));
		wr(icu_pkg::OFF_IRQ_EN, 1);
		irqIs(1'b1);
		wr(icu_pkg::OFF_IRQ_EN, 2);
		irqIs(1'b0);
		wr(icu_pkg::OFF_IRQ_EN, 1);
		wr(icu_pkg::OFF_FLAGS, 1);
		irqIs(1'b0);
		rd(icu_pkg::OFF_FLAGS, ok(0));
		report_and_stop();
	end
endmodule // tb_top
